// file: core/timer0_pkg.sv
// Overview of operation
// RQ1: control register A sits at data offset 0x44, I/O offset 0x24, resets 0x00.
// RQ2: bits 7:6 channel A mode, 5:4 channel B mode, 1:0 waveform low bits.
// RQ3: nonzero channel A mode hands the pin to compare_out_a; direction bit enables driver. Code keeps port data for 01 in PWM without bit2.
// RQ4: non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// RQ5: fast PWM channel A: 10 non-inverting, 11 inverting, 01 toggles only with bit2.
// RQ6: fast PWM channel A with compare at TOP ignores match, keeps BOTTOM action.
// RQ7: phase correct channel A: 10 clear up/set down, 11 opposite, 01 toggle with bit2.
// RQ8: phase correct channel A with compare at TOP ignores match, acts at TOP.
// RQ9: nonzero channel B mode hands the pin to compare_out_b; direction bit enables driver. Code keeps port data for 01 in PWM modes.
// RQ10: non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// RQ11: fast PWM channel B: 01 reserved, 10 non-inverting, 11 inverting.
// RQ12: fast PWM channel B with compare at TOP ignores match, acts at TOP.
// RQ13: phase correct channel B: 01 reserved, 10 clear up/set down, 11 opposite.
// RQ14: phase correct channel B with compare at TOP skips match, acts at TOP.
// RQ15: waveform mode is bit2 from control B plus two low bits here.
// RQ16: mode map: normal, phase, clear-on-match, fast, reserved, phase, reserved, fast.
// RQ17: compare update and overflow flag moment depend on waveform mode.
// RQ18: phase correct modes count up to TOP then down to BOTTOM.
// RQ19: software avoids reserved waveform modes and channel B code 01 in PWM.
package timer0_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_A_DATA_OFFSET = 8'h44;
  localparam logic [7:0] CTRL_A_IO_OFFSET = 8'h24;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_WRITE_MASK = 8'hF3;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CHAN_A_MODE_POS = 6;
  localparam int CHAN_B_MODE_POS = 4;
  localparam int WAVE_LOW_POS = 0;

  // ------------------------------------------------------------
  // counter limits and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;

  // ------------------------------------------------------------
  // waveform modes
  // ------------------------------------------------------------
  localparam logic [2:0] WAVE_NORMAL = 3'h0;
  localparam logic [2:0] WAVE_PHASE_MAX = 3'h1;
  localparam logic [2:0] WAVE_MATCH_CLR = 3'h2;
  localparam logic [2:0] WAVE_FAST_MAX = 3'h3;
  localparam logic [2:0] WAVE_RSVD_4 = 3'h4;
  localparam logic [2:0] WAVE_PHASE_CMP = 3'h5;
  localparam logic [2:0] WAVE_RSVD_6 = 3'h6;
  localparam logic [2:0] WAVE_FAST_CMP = 3'h7;

  // ------------------------------------------------------------
  // output mode codes
  // ------------------------------------------------------------
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR = 2'h2;
  localparam logic [1:0] OUT_SET = 2'h3;

endpackage : timer0_pkg

// file: core/timer0_waveform_mode_control.sv
`timescale 1ns/100ps
module timer0_waveform_mode_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic io_space,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic timer_tick,
  input wire logic waveform_mode_bit2,
  input wire logic [7:0] compare_value_a,
  input wire logic [7:0] compare_value_b,
  input wire logic port_direction_bit_a,
  input wire logic port_direction_bit_b,
  input wire logic port_data_a,
  input wire logic port_data_b,
  output logic pin_a_out,
  output logic pin_a_oe_n,
  output logic pin_b_out,
  output logic pin_b_oe_n,
  output logic compare_out_a,
  output logic compare_out_b,
  output logic [7:0] count_value,
  output logic count_down,
  output logic overflow_flag
);
  import timer0_pkg::*;

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  logic [7:0] ctrl_a_r;
  logic hit;

  assign hit = io_space ? (reg_addr == CTRL_A_IO_OFFSET) :
               (reg_addr == CTRL_A_DATA_OFFSET); // RQ1

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_a_r <= CTRL_A_RESET; // RQ1
    end else if (reg_wr && hit) begin
      ctrl_a_r <= reg_wdata & CTRL_A_WRITE_MASK; // RQ2
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && hit) begin
      reg_rdata <= ctrl_a_r;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic [2:0] wave_mode;
  logic is_fast;
  logic is_phase;
  logic immediate_upd;
  logic top_from_cmp;

  assign wave_mode = {waveform_mode_bit2, ctrl_a_r[WAVE_LOW_POS +: 2]}; // RQ15
  assign is_fast = (wave_mode == WAVE_FAST_MAX) || (wave_mode == WAVE_FAST_CMP); // RQ16
  assign is_phase = (wave_mode == WAVE_PHASE_MAX) || (wave_mode == WAVE_PHASE_CMP); // RQ16
  assign immediate_upd = !is_fast && !is_phase; // RQ17
  assign top_from_cmp = (wave_mode == WAVE_MATCH_CLR) || (wave_mode == WAVE_PHASE_CMP) ||
                        (wave_mode == WAVE_FAST_CMP); // RQ16

  // ------------------------------------------------------------
  // compare buffers
  // ------------------------------------------------------------
  logic [7:0] cmp_in [2];
  logic [7:0] cmp_act_r [2];
  logic [7:0] cnt_r;
  logic up_r;
  logic [7:0] top;
  logic at_top;
  logic cmp_upd;

  assign cmp_in[0] = compare_value_a;
  assign cmp_in[1] = compare_value_b;
  assign top = top_from_cmp ? cmp_act_r[0] : COUNT_MAX; // RQ16
  assign at_top = (cnt_r == top);
  assign cmp_upd = immediate_upd || (timer_tick && at_top && (is_fast || (is_phase && up_r))); // RQ17

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= COUNT_BOTTOM;
    end else if (timer_tick) begin
      if (is_phase) begin
        if (up_r) begin
          cnt_r <= at_top ? cnt_r - 8'h01 : cnt_r + 8'h01; // RQ18
        end else begin
          cnt_r <= (cnt_r == COUNT_BOTTOM) ? cnt_r + 8'h01 : cnt_r - 8'h01; // RQ18
        end
      end else if (at_top) begin
        cnt_r <= COUNT_BOTTOM; // RQ16
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      up_r <= 1'b1;
    end else if (!is_phase) begin
      up_r <= 1'b1;
    end else if (timer_tick && up_r && at_top) begin
      up_r <= 1'b0; // RQ18
    end else if (timer_tick && !up_r && (cnt_r == COUNT_BOTTOM)) begin
      up_r <= 1'b1; // RQ18
    end
  end

  // ------------------------------------------------------------
  // overflow flag
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (!timer_tick) begin
      overflow_flag <= 1'b0;
    end else if (is_phase) begin
      overflow_flag <= !up_r && (cnt_r == COUNT_BOTTOM); // RQ17
    end else if (wave_mode == WAVE_FAST_CMP) begin
      overflow_flag <= at_top; // RQ17
    end else begin
      overflow_flag <= (cnt_r == COUNT_MAX); // RQ17
    end
  end

  assign count_value = cnt_r;
  assign count_down = !up_r;

  // ------------------------------------------------------------
  // compare channels
  // ------------------------------------------------------------
  logic oc_r [2];
  logic link [2];
  logic pdir [2];
  logic pdat [2];
  logic pin_out_r [2];
  logic pin_oe_n_r [2];

  assign pdir[0] = port_direction_bit_a;
  assign pdir[1] = port_direction_bit_b;
  assign pdat[0] = port_data_a;
  assign pdat[1] = port_data_b;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [1:0] com;
      logic toggle_ok;
      logic match;
      logic cmp_is_top;

      assign com = ctrl_a_r[(ch == 0 ? CHAN_A_MODE_POS : CHAN_B_MODE_POS) +: 2]; // RQ2
      assign toggle_ok = (ch == 0) && waveform_mode_bit2; // RQ5 RQ7 RQ11 RQ13
      assign match = (cnt_r == cmp_act_r[ch]);
      assign cmp_is_top = (cmp_act_r[ch] == top);
      assign link[ch] = (com != OUT_OFF) &&
                        !((is_fast || is_phase) && (com == OUT_TOGGLE) && !toggle_ok); // RQ3 RQ9

      always_ff @(posedge clock) begin
        if (rst) begin
          cmp_act_r[ch] <= COMPARE_RESET;
        end else if (cmp_upd) begin
          cmp_act_r[ch] <= cmp_in[ch]; // RQ17
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          oc_r[ch] <= 1'b0;
        end else if (timer_tick) begin
          if (is_fast) begin
            if (com[1]) begin
              if (at_top) begin
                oc_r[ch] <= !com[0]; // RQ5 RQ6 RQ11 RQ12
              end else if (match && !cmp_is_top) begin
                oc_r[ch] <= com[0]; // RQ5 RQ11
              end
            end else if (com == OUT_TOGGLE && toggle_ok && match) begin
              oc_r[ch] <= !oc_r[ch]; // RQ5
            end
          end else if (is_phase) begin
            if (com[1]) begin
              if (cmp_is_top) begin
                if (at_top) begin
                  oc_r[ch] <= !com[0]; // RQ8 RQ14
                end
              end else if (match) begin
                oc_r[ch] <= up_r ? com[0] : !com[0]; // RQ7 RQ13
              end
            end else if (com == OUT_TOGGLE && toggle_ok && match) begin
              oc_r[ch] <= !oc_r[ch]; // RQ7
            end
          end else if (match) begin
            case (com)
              OUT_TOGGLE: oc_r[ch] <= !oc_r[ch]; // RQ4 RQ10
              OUT_CLEAR: oc_r[ch] <= 1'b0; // RQ4 RQ10
              OUT_SET: oc_r[ch] <= 1'b1; // RQ4 RQ10
              default: oc_r[ch] <= oc_r[ch];
            endcase
          end
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          pin_out_r[ch] <= 1'b0;
          pin_oe_n_r[ch] <= 1'b1;
        end else begin
          pin_out_r[ch] <= link[ch] ? oc_r[ch] : pdat[ch]; // RQ3 RQ9
          pin_oe_n_r[ch] <= !pdir[ch]; // RQ3 RQ9
        end
      end
    end
  endgenerate

  assign compare_out_a = oc_r[0];
  assign compare_out_b = oc_r[1];
  assign pin_a_out = pin_out_r[0];
  assign pin_a_oe_n = pin_oe_n_r[0];
  assign pin_b_out = pin_out_r[1];
  assign pin_b_oe_n = pin_oe_n_r[1];

endmodule : timer0_waveform_mode_control

// file: testbench/timer0_waveform_mode_control_checker.sv
`timescale 1ns/100ps
module timer0_waveform_mode_control_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic io_space,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic timer_tick,
  input wire logic waveform_mode_bit2,
  input wire logic [7:0] compare_value_a,
  input wire logic [7:0] compare_value_b,
  input wire logic port_direction_bit_a,
  input wire logic port_data_a,
  input wire logic pin_a_out,
  input wire logic pin_a_oe_n,
  input wire logic compare_out_a,
  input wire logic compare_out_b,
  input wire logic [7:0] count_value,
  input wire logic count_down,
  input wire logic overflow_flag
);
  // ----------------------------------------
  // shadow of control register and mode
  // ----------------------------------------
  logic [7:0] ctl_r;
  logic hit;
  logic [2:0] md;
  assign hit = reg_addr == (io_space ? 8'h24 : 8'h44);
  assign md = {waveform_mode_bit2, ctl_r[1:0]};
  always_ff @(posedge clock) begin
    if (rst) ctl_r <= 8'h00;
    else if (reg_wr && hit) ctl_r <= reg_wdata & 8'hF3;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  reg_read_a: assert property (reg_rd && hit && !reg_wr |=> reg_rdata == $past(ctl_r))
    else $error("readback mismatch");
  unmapped_zero_a: assert property (reg_rd && !hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  oe_follow_a: assert property (1'b1 |=> pin_a_oe_n == !$past(port_direction_bit_a))
    else $error("pin enable wrong");
  pin_port_a: assert property (ctl_r[7:6] == 2'h0 |=> pin_a_out == $past(port_data_a))
    else $error("port data not on pin");
  pin_cmp_a: assert property (ctl_r[7] |=> pin_a_out == $past(compare_out_a))
    else $error("compare output not on pin");
  match_a_a: assert property (timer_tick && !md[0] && !md[2] && ctl_r[7]
    && count_value == compare_value_a && $stable(compare_value_a) |=> compare_out_a == $past(ctl_r[6]))
    else $error("channel a match action wrong");
  match_b_a: assert property (timer_tick && !md[0] && !md[2] && ctl_r[5]
    && count_value == compare_value_b && $stable(compare_value_b) |=> compare_out_b == $past(ctl_r[4]))
    else $error("channel b match action wrong");
  fast_bottom_a: assert property (timer_tick && md == 3'h3 && ctl_r[7] && count_value == 8'hFF
    |=> compare_out_a == !$past(ctl_r[6]))
    else $error("bottom action wrong");
  ovf_max_a: assert property (timer_tick && md inside {3'h0, 3'h2, 3'h3} && count_value == 8'hFF
    |=> overflow_flag)
    else $error("overflow flag missing");
  phase_turn_a: assert property (timer_tick && md == 3'h1 && count_value == 8'hFF
    |=> count_down && count_value == 8'hFE)
    else $error("no turn at top");
endmodule : timer0_waveform_mode_control_checker
bind timer0_waveform_mode_control timer0_waveform_mode_control_checker u_chk (.*);

// file: testbench/timer0_waveform_mode_control_tb_top.sv
`timescale 1ns/100ps
module timer0_waveform_mode_control_tb_top;
  // ----------------------------------------
  // signals and tables
  // ----------------------------------------
  logic clock, rst, io_space, reg_wr, reg_rd, timer_tick, waveform_mode_bit2;
  logic port_direction_bit_a, port_direction_bit_b, port_data_a, port_data_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, compare_value_a, compare_value_b, count_value;
  logic pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n, compare_out_a, compare_out_b;
  logic count_down, overflow_flag, oa;
  int bad_count, cmp_count, ovf_n;
  logic [7:0] cd [4] = '{8'hF0, 8'hA0, 8'h50, 8'h50};
  logic [3:0] ex = 4'b0101;
  logic [2:0] md [6] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h5, 3'h7};
  int nt [6] = '{256, 256, 256, 510, 180, 100};
  logic [7:0] ne [6] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h0A, 8'h0A};
  timer0_waveform_mode_control u_dut (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) if (overflow_flag === 1'b1) ovf_n <= ovf_n + 1;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    {io_space, reg_addr} <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clock);
    {io_space, reg_addr} <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(reg_rdata, e);
  endtask : rd
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clock);
      timer_tick <= 1'b1;
    end
    @(posedge clock);
    timer_tick <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : tk
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {io_space, reg_wr, reg_rd, timer_tick, waveform_mode_bit2, port_data_a, port_data_b} = '0;
    {reg_addr, reg_wdata, compare_value_a, compare_value_b} = '0;
    {port_direction_bit_a, port_direction_bit_b, rst} = 3'b111;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(9'h044, 8'h00);
    wr(9'h044, 8'hFF);
    rd(9'h124, 8'hF3);
    wr(9'h045, 8'h00);
    rd(9'h144, 8'h00);
    rd(9'h044, 8'hF3);
    compare_value_a <= 8'h10;
    compare_value_b <= 8'h20;
    for (int i = 0; i < 4; i++) begin
      wr(9'h044, cd[i]);
      tk(256);
      chk(8'(compare_out_a), 8'(ex[i]));
      chk(8'(compare_out_b), 8'(ex[i]));
      chk(8'(pin_a_out), 8'(ex[i]));
      chk(8'(pin_b_out), 8'(ex[i]));
    end
    wr(9'h044, 8'h00);
    port_data_a <= 1'b1;
    port_direction_bit_a <= 1'b0;
    tk(0);
    chk(8'(pin_a_out), 8'h01);
    chk(8'(pin_a_oe_n), 8'h01);
    compare_value_a <= 8'h09;
    for (int i = 0; i < 6; i++) begin
      waveform_mode_bit2 <= md[i][2];
      wr(9'h044, {6'h00, md[i][1:0]});
      tk(600);
      ovf_n = 0;
      tk(nt[i]);
      chk(8'(ovf_n), ne[i]);
    end
    waveform_mode_bit2 <= 1'b0;
    compare_value_a <= 8'hFF;
    wr(9'h044, 8'h83);
    tk(600);
    chk(8'(compare_out_a), 8'h01);
    wr(9'h044, 8'hC3);
    tk(300);
    chk(8'(compare_out_a), 8'h00);
    wr(9'h044, 8'h43);
    port_direction_bit_a <= 1'b1;
    tk(0);
    chk(8'(pin_a_out), 8'h01);
    compare_value_a <= 8'h40;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    wr(9'h044, 8'hC1);
    tk(460);
    chk(8'(compare_out_a), 8'h00);
    tk(140);
    chk(8'(compare_out_a), 8'h01);
    compare_value_a <= 8'hFF;
    compare_value_b <= 8'hFF;
    wr(9'h044, 8'hE1);
    tk(1100);
    chk(8'(compare_out_a), 8'h00);
    chk(8'(compare_out_b), 8'h01);
    chk(8'(pin_b_out), 8'h01);
    chk(8'(pin_b_oe_n), 8'h00);
    wr(9'h044, 8'h33);
    tk(600);
    chk(8'(compare_out_b), 8'h00);
    compare_value_a <= 8'h09;
    waveform_mode_bit2 <= 1'b1;
    wr(9'h044, 8'h43);
    tk(600);
    oa = compare_out_a;
    tk(50);
    chk(8'(compare_out_a), 8'(!oa));
    chk(8'(pin_a_out), 8'(!oa));
    report_and_stop();
  end
endmodule : timer0_waveform_mode_control_tb_top
